// *** src/pins_pkg.sv ***
// Constants, types and carriers shared by the strobe and port logic.
// Assumes clk runs at twice the crystal input rate, so one crystal cycle is two clocks.
package pins_pkg;

  // ==========================================================================
  // Timing
  // ==========================================================================
  localparam int CLK_NS = 10;
  localparam int XTAL_NS = 20;
  // High time of the latch strobe in tenths of a crystal cycle (1.5 cycles).
  localparam int ALE_HIGH_X10 = 15;
  localparam int ALE_PERIOD_XTAL = 4;
  localparam int ALE_HIGH_CYC = (ALE_HIGH_X10 * XTAL_NS + 10 * CLK_NS - 1) / (10 * CLK_NS);
  localparam int ALE_PERIOD_CYC = ALE_PERIOD_XTAL * XTAL_NS / CLK_NS;
  // Strong pull-up kick after a 0 to 1 change of a port bit.
  localparam int BOOST_NS = 20;
  localparam int BOOST_CYC = (BOOST_NS + CLK_NS - 1) / CLK_NS;

  // ==========================================================================
  // Phases within one strobe period, and the kick counter load
  // ==========================================================================
  localparam logic [2:0] PH_LAST = 3'(ALE_PERIOD_CYC - 1);
  localparam logic [2:0] PH_ADDR_LAST = 3'(ALE_HIGH_CYC - 1);
  localparam logic [2:0] PH_PROGRAM_STORE_STROBE_N_FIRST = 3'h4;
  localparam logic [2:0] PH_PROGRAM_STORE_STROBE_N_LAST = 3'h6;
  localparam logic [2:0] PH_RD_SAMPLE = 3'h6;
  localparam logic [1:0] BOOST_LOAD = 2'(BOOST_CYC);

  // ==========================================================================
  // Reset values and bit positions
  // ==========================================================================
  localparam logic [7:0] P0_RESET = 8'hff;
  localparam logic [7:0] P1_RESET = 8'hff;
  localparam int BIT_T2 = 0;
  localparam int BIT_TIMER2_TRIGGER_PIN = 1;
  localparam int BIT_RX1 = 2;
  localparam int BIT_TX1 = 3;
  localparam int BIT_RISE_A = 4;
  localparam int BIT_FALL_A = 5;
  localparam int BIT_RISE_B = 6;
  localparam int BIT_FALL_B = 7;

  // ==========================================================================
  // Types
  // ==========================================================================
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_ADDR = 2'b01,
    ST_DATA = 2'b10
  } bus_state_t;

  typedef struct packed {
    logic is_code;
    logic write;
    logic [15:0] addr;
    logic [7:0] wdata;
  } ext_cmd_t;

  typedef struct packed {
    logic [7:0] o;
    logic [7:0] oe;
  } pins8_t;

endpackage

// *** src/latch_strobe_gen.sv ***
// Phase counter that paces the address latch strobe and external accesses.
// Assumes one free-running clock at twice the crystal input rate.
`timescale 1ns/1ns
module latch_strobe_gen
  import pins_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  output logic [2:0] phase,
  output logic ale_window
);

  // ==========================================================================
  // Period counter
  // ==========================================================================
  // Wraps every strobe period of four crystal cycles.
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      phase <= 3'h0;
    else if (phase == PH_LAST)
      phase <= 3'h0; // see [RL2]
    else
      phase <= phase + 3'h1;
  end

  // The strobe window is the first 1.5 crystal cycles of each period.
  assign ale_window = (phase <= PH_ADDR_LAST); // see [RL2]

endmodule

// *** src/qb_port_bit.sv ***
// One quasi-bidirectional port bit: output latch, strong pulldown, pull-up kick.
// Assumes a weak pullup on the pin wherever the output enable is low.
`timescale 1ns/1ns
module qb_port_bit
  import pins_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic wr,
  input wire logic wdata,
  input wire logic alt_out,
  output logic latch,
  output logic pin_out,
  output logic pin_oe
);

  logic eff;
  logic eff_prev;
  logic [1:0] boost;
  logic [1:0] next_boost;

  // ==========================================================================
  // Output latch
  // ==========================================================================
  // Comes out of reset at 1 so the pin idles high and reads as an input.
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      latch <= 1'b1; // see [RL11]
    else if (wr)
      latch <= wdata; // see [RL12]
  end

  // The alternate output can only pull the pin low when the latch is 1.
  assign eff = latch & alt_out;

  // ==========================================================================
  // Pull-up kick
  // ==========================================================================
  // A rising effective value loads a short strong drive, then it decays.
  always_comb
  begin
    if (eff && !eff_prev)
      next_boost = BOOST_LOAD; // see [RL13]
    else if (boost != 2'h0)
      next_boost = boost - 2'h1;
    else
      next_boost = 2'h0;
  end

  // Tracks the previous value and the kick counter.
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      eff_prev <= 1'b1;
      boost <= 2'h0;
    end
    else
    begin
      eff_prev <= eff;
      boost <= next_boost;
    end
  end

  // Low drives strongly; high drives only during the kick, else weak pullup.
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      pin_out <= 1'b1;
      pin_oe <= 1'b0;
    end
    else
    begin
      pin_out <= eff;
      pin_oe <= !eff || (next_boost != 2'h0); // see [RL12] see [RL13]
    end
  end

  // ==========================================================================
  // Checks
  // ==========================================================================
  property p_pulldown;
    @(posedge clk) disable iff (!rstn)
      wr && !wdata |-> ##2 (pin_oe && !pin_out);
  endproperty
  a_pulldown: assert property (p_pulldown) else $error("Written 0 did not pull pin low."); // see [RL12]

  property p_kick;
    @(posedge clk) disable iff (!rstn)
      $rose(pin_out) |-> pin_oe[*2] ##1 (!pin_oe || !pin_out);
  endproperty
  a_kick: assert property (p_kick) else $error("Pull-up kick has the wrong length."); // see [RL13]

endmodule

// *** src/ext_bus_strobes_and_ports.sv ***
// External bus strobes, the open-drain low port and the quasi-bidirectional second port.
// Assumes all pin inputs are synchronous to clk and clk runs at twice the crystal rate.
//
// What this block does
// [RL1] Program-store strobe pulses low for external code reads, otherwise stays high.
// [RL2] Latch strobe is high 1.5 crystal cycles every four crystal cycles.
// [RL3] Latch strobe is forced high while reset is held.
// [RL4] Suppress bit set to 1 stops latch strobe pulses and holds it high.
// [RL5] External accesses still pulse the latch strobe whatever the suppress bit says.
// [RL6] Low port carries address low byte while the latch strobe is high.
// [RL7] After latch strobe falls, low port becomes the data bus until access ends.
// [RL8] External latch captures the low address byte using the latch strobe.
// [RL9] Low port is open-drain for I/O, active-high drivers when it is the bus.
// [RL10] Reset leaves every low-port pin undriven.
// [RL11] Reset sets all second-port latches to 1, pins held high weakly.
// [RL12] Writing 0 to a second-port bit turns on a strong pulldown until changed.
// [RL13] Writing 1 after 0 gives a brief strong pull-up, then weak pullup.
// [RL14] Second-port bits 0 to 3 carry timer 2 and serial port 1 functions.
// [RL15] Rising edge on bit 4 and falling edge on bit 5 raise interrupts.
// [RL16] Rising edge on bit 6 and falling edge on bit 7 raise interrupts.
// [RL17] High address port carries the address upper byte during external accesses.
// [RL18] Software keeps a latch at 1 where its pin serves as an input.
`timescale 1ns/1ns
module ext_bus_strobes_and_ports
  import pins_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic latch_strobe_suppress,
  input wire logic ext_req,
  input wire ext_cmd_t ext_cmd,
  output logic ext_busy,
  output logic ext_done,
  output logic [7:0] ext_rdata,
  input wire logic p0_wr,
  input wire logic [7:0] p0_wdata,
  input wire logic p1_wr,
  input wire logic [7:0] p1_wdata,
  output logic [7:0] p1_latch,
  input wire logic timer2_io_drive,
  input wire logic serial1_transmit,
  output logic timer2_io_pin,
  output logic timer2_trigger_pin,
  output logic serial1_receive,
  output logic ext_irq_rise_a,
  output logic ext_irq_fall_a,
  output logic ext_irq_rise_b,
  output logic ext_irq_fall_b,
  output logic latch_strobe,
  output logic program_store_strobe_n,
  input wire logic [7:0] low_bus_in,
  output pins8_t low_addr_data_bus,
  output logic [7:0] high_addr_port,
  output logic high_addr_drive,
  input wire logic [7:0] p1_pin_in,
  output pins8_t p1_drive
);

  // Reports an edge of the wanted direction between two samples.
  function automatic logic edge_seen(input logic cur, input logic prev, input logic rising);
    edge_seen = rising ? (cur && !prev) : (!cur && prev);
  endfunction

  logic [2:0] phase;
  logic ale_window;
  bus_state_t state;
  bus_state_t next_state;
  ext_cmd_t req_q;
  logic take;
  logic active;
  logic [7:0] p0_latch;
  logic [7:0] p1_sync;
  logic [7:0] p1_prev;
  logic [7:0] alt_vec;

  // ==========================================================================
  // Strobe timing
  // ==========================================================================
  latch_strobe_gen u_gen (
    .clk(clk),
    .rstn(rstn),
    .phase(phase),
    .ale_window(ale_window)
  );

  // ==========================================================================
  // External access sequencer
  // ==========================================================================
  // A request is taken only at the end of a period, so accesses align to it.
  assign take = (state == ST_IDLE) && ext_req && (phase == PH_LAST);
  assign active = (state != ST_IDLE);

  // Address phase spans the strobe window, data phase the rest of the period.
  always_comb
  begin
    case (state)
      ST_IDLE: next_state = take ? ST_ADDR : ST_IDLE;
      ST_ADDR: next_state = (phase == PH_ADDR_LAST) ? ST_DATA : ST_ADDR; // see [RL7]
      ST_DATA: next_state = (phase == PH_LAST) ? ST_IDLE : ST_DATA;
      default: next_state = ST_IDLE;
    endcase
  end

  // State register.
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      state <= ST_IDLE;
    else
      state <= next_state;
  end

  // The command is held stable for the whole access.
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      req_q <= '0;
    else if (take)
      req_q <= ext_cmd;
  end

  // Status toward the core, and the read data captured late in the data phase.
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      ext_busy <= 1'b0;
      ext_done <= 1'b0;
      ext_rdata <= 8'h00;
    end
    else
    begin
      ext_busy <= active;
      ext_done <= (state == ST_DATA) && (phase == PH_LAST);
      if ((state == ST_DATA) && !req_q.write && (phase == PH_RD_SAMPLE))
        ext_rdata <= low_bus_in;
    end
  end

  // ==========================================================================
  // Strobes
  // ==========================================================================
  // Suppression only holds the strobe high when no access is running.
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      latch_strobe <= 1'b1; // see [RL3]
    else if (latch_strobe_suppress && !active)
      latch_strobe <= 1'b1; // see [RL4]
    else
      latch_strobe <= ale_window; // see [RL2] see [RL5]
  end

  // Code reads drop the program-store strobe in the middle of the data phase.
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      program_store_strobe_n <= 1'b1;
    else
      program_store_strobe_n <= !((state == ST_DATA) && req_q.is_code
        && (phase >= PH_PROGRAM_STORE_STROBE_N_FIRST) && (phase <= PH_PROGRAM_STORE_STROBE_N_LAST)); // see [RL1]
  end

  // ==========================================================================
  // Low port and high address port
  // ==========================================================================
  // General purpose latch of the open-drain low port; all ones floats the pins.
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      p0_latch <= P0_RESET; // see [RL10]
    else if (p0_wr)
      p0_latch <= p0_wdata;
  end

  // The address goes out with the strobe; the external latch holds it after.
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      low_addr_data_bus <= '0; // see [RL10]
    else
    begin
      case (state)
        ST_ADDR:
        begin
          low_addr_data_bus.o <= req_q.addr[7:0]; // see [RL6] see [RL8]
          low_addr_data_bus.oe <= 8'hff; // see [RL9]
        end
        ST_DATA:
        begin
          low_addr_data_bus.o <= req_q.write ? req_q.wdata : 8'h00; // see [RL7]
          low_addr_data_bus.oe <= req_q.write ? 8'hff : 8'h00;
        end
        default:
        begin
          low_addr_data_bus.o <= 8'h00;
          low_addr_data_bus.oe <= ~p0_latch; // see [RL9]
        end
      endcase
    end
  end

  // The upper address byte is driven for every external access.
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      high_addr_port <= 8'h00;
      high_addr_drive <= 1'b0;
    end
    else
    begin
      high_addr_drive <= active;
      if (active)
        high_addr_port <= req_q.addr[15:8]; // see [RL17]
    end
  end

  // ==========================================================================
  // Second port
  // ==========================================================================
  // Alternate outputs; software leaves input bits' latches at 1 (see [RL18]).
  always_comb
  begin
    alt_vec = 8'hff;
    alt_vec[BIT_T2] = timer2_io_drive; // see [RL14]
    alt_vec[BIT_TX1] = serial1_transmit; // see [RL14]
  end

  // One quasi-bidirectional cell per pin.
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi = gi + 1)
    begin : g_p1
      qb_port_bit u_bit (
        .clk(clk),
        .rstn(rstn),
        .wr(p1_wr),
        .wdata(p1_wdata[gi]),
        .alt_out(alt_vec[gi]),
        .latch(p1_latch[gi]),
        .pin_out(p1_drive.o[gi]),
        .pin_oe(p1_drive.oe[gi])
      );
    end
  endgenerate

  // Pin samples for the alternate inputs and the edge detectors.
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      p1_sync <= P1_RESET;
      p1_prev <= P1_RESET;
    end
    else
    begin
      p1_sync <= p1_pin_in;
      p1_prev <= p1_sync;
    end
  end

  // Alternate inputs and one-cycle interrupt requests.
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      timer2_io_pin <= 1'b1;
      timer2_trigger_pin <= 1'b1;
      serial1_receive <= 1'b1;
      ext_irq_rise_a <= 1'b0;
      ext_irq_fall_a <= 1'b0;
      ext_irq_rise_b <= 1'b0;
      ext_irq_fall_b <= 1'b0;
    end
    else
    begin
      timer2_io_pin <= p1_sync[BIT_T2]; // see [RL14]
      timer2_trigger_pin <= p1_sync[BIT_TIMER2_TRIGGER_PIN]; // see [RL14]
      serial1_receive <= p1_sync[BIT_RX1]; // see [RL14]
      ext_irq_rise_a <= edge_seen(p1_sync[BIT_RISE_A], p1_prev[BIT_RISE_A], 1'b1); // see [RL15]
      ext_irq_fall_a <= edge_seen(p1_sync[BIT_FALL_A], p1_prev[BIT_FALL_A], 1'b0); // see [RL15]
      ext_irq_rise_b <= edge_seen(p1_sync[BIT_RISE_B], p1_prev[BIT_RISE_B], 1'b1); // see [RL16]
      ext_irq_fall_b <= edge_seen(p1_sync[BIT_FALL_B], p1_prev[BIT_FALL_B], 1'b0); // see [RL16]
    end
  end

  // ==========================================================================
  // Checks
  // ==========================================================================
  property p_program_store_strobe_n_idle;
    @(posedge clk) disable iff (!rstn)
      !ext_busy |-> program_store_strobe_n;
  endproperty
  a_program_store_strobe_n_idle: assert property (p_program_store_strobe_n_idle) else $error("Store strobe low outside access."); // see [RL1]

  property p_ale_period;
    @(posedge clk) disable iff (!rstn)
      $rose(latch_strobe) |-> ##8 latch_strobe;
  endproperty
  a_ale_period: assert property (p_ale_period) else $error("Latch strobe period is wrong."); // see [RL2]

  property p_ale_width;
    @(posedge clk) disable iff (!rstn)
      $rose(latch_strobe) && ext_busy |-> latch_strobe[*3] ##1 !latch_strobe;
  endproperty
  a_ale_width: assert property (p_ale_width) else $error("Latch strobe width is wrong."); // see [RL2] see [RL5]

  property p_ale_reset;
    @(posedge clk) $rose(rstn) |-> latch_strobe && (low_addr_data_bus.oe == 8'h00);
  endproperty
  a_ale_reset: assert property (p_ale_reset) else $error("Reset state of strobe or port wrong."); // see [RL3] see [RL10]

  property p_suppress;
    @(posedge clk) disable iff (!rstn)
      $past(latch_strobe_suppress) && !ext_busy |-> latch_strobe;
  endproperty
  a_suppress: assert property (p_suppress) else $error("Suppressed latch strobe pulsed."); // see [RL4]

  property p_addr_out;
    @(posedge clk) disable iff (!rstn)
      latch_strobe && ext_busy |->
        (low_addr_data_bus.oe == 8'hff) && (low_addr_data_bus.o == req_q.addr[7:0]);
  endproperty
  a_addr_out: assert property (p_addr_out) else $error("Address low byte not on bus."); // see [RL6]

  property p_data_turn;
    @(posedge clk) disable iff (!rstn)
      $fell(latch_strobe) && ext_busy && !req_q.write |-> (low_addr_data_bus.oe == 8'h00) [*5];
  endproperty
  a_data_turn: assert property (p_data_turn) else $error("Low port not released for read."); // see [RL7]

  property p_addr_hi;
    @(posedge clk) disable iff (!rstn)
      ext_busy |-> high_addr_drive && (high_addr_port == req_q.addr[15:8]);
  endproperty
  a_addr_hi: assert property (p_addr_hi) else $error("High address byte wrong."); // see [RL17]

  property p_irq_edges;
    @(posedge clk) disable iff (!rstn)
      (p1_sync[BIT_FALL_B] == 1'b0) && p1_prev[BIT_FALL_B] ##1 1'b1 |-> ext_irq_fall_b;
  endproperty
  a_irq_edges: assert property (p_irq_edges) else $error("Falling edge interrupt missed."); // see [RL16]

  property p_irq_rise;
    @(posedge clk) disable iff (!rstn)
      $rose(p1_sync[BIT_RISE_A]) |=> ext_irq_rise_a ##1 !ext_irq_rise_a;
  endproperty
  a_irq_rise: assert property (p_irq_rise) else $error("Rising edge interrupt wrong."); // see [RL15]

  c_code_read: cover property (@(posedge clk) disable iff (!rstn) ext_done && req_q.is_code);
  c_write: cover property (@(posedge clk) disable iff (!rstn) ext_done && req_q.write);
  c_sup_access: cover property (@(posedge clk) disable iff (!rstn)
    latch_strobe_suppress && $rose(ext_busy));
  c_irq_fall_a: cover property (@(posedge clk) disable iff (!rstn) ext_irq_fall_a);

endmodule

// *** tb/ext_mem_model.sv ***
// External address latch and byte memory hung on the multiplexed low port.
// Assumes pullups on the low port, so an undriven line reads 1.
`timescale 1ns/1ns
module ext_mem_model
  import pins_pkg::*;
(
  input wire logic clk,
  input wire logic latch_strobe,
  input wire logic program_store_strobe_n,
  input wire pins8_t low_addr_data_bus,
  input wire logic [7:0] high_addr_port,
  input wire logic high_addr_drive,
  output logic [7:0] low_bus_in
);
  logic [7:0] addr_lo;
  logic [7:0] mem [0:65535];
  logic [7:0] rd;
  logic drv;
  // ==========================================================================
  // Latch, memory and bus resolution
  // ==========================================================================
  // The latch tracks the bus while the strobe is high, clocked to give it hold time.
  always @(posedge clk)
  begin
    if (latch_strobe)
      addr_lo <= low_addr_data_bus.o;
  end
  // A driven data phase is stored as a write.
  always @(posedge clk)
  begin
    if (high_addr_drive && !latch_strobe && low_addr_data_bus.oe == 8'hff)
      mem[{high_addr_port, addr_lo}] <= low_addr_data_bus.o;
  end
  // Code space answers under the store strobe, data space otherwise.
  always_comb
  begin
    if (!program_store_strobe_n)
      rd = addr_lo ^ high_addr_port ^ 8'h5a;
    else
      rd = mem[{high_addr_port, addr_lo}];
    drv = high_addr_drive && !latch_strobe;
  end
  // Undriven lines fall back to the pullups.
  assign low_bus_in = (low_addr_data_bus.oe & low_addr_data_bus.o) |
                      (~low_addr_data_bus.oe & (drv ? rd : 8'hff));
endmodule

// *** tb/ext_bus_strobes_and_ports_bench.sv ***
// Self-checking bench for the bus strobes, the low port and the second port.
// Assumes the memory model on the low port and a pullup on every second-port pin.
`timescale 1ns/1ns
module ext_bus_strobes_and_ports_bench
  import pins_pkg::*;
();
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic latch_strobe_suppress = 1'b0;
  logic ext_req = 1'b0;
  ext_cmd_t ext_cmd = '0;
  logic p0_wr = 1'b0, p1_wr = 1'b0, timer2_io_drive = 1'b1, serial1_transmit = 1'b1;
  logic [7:0] p0_wdata = 8'hff, p1_wdata = 8'hff, p1_ext = 8'hff;
  logic ext_busy, ext_done, timer2_io_pin, timer2_trigger_pin, serial1_receive;
  logic ext_irq_rise_a, ext_irq_fall_a, ext_irq_rise_b, ext_irq_fall_b;
  logic latch_strobe, program_store_strobe_n, high_addr_drive;
  logic [7:0] ext_rdata, p1_latch, low_bus_in, high_addr_port, p1_pin_in;
  pins8_t low_addr_data_bus, p1_drive;
  logic [31:0] seed = 32'hb0f57d81;
  int num_errors = 0;
  int n_tests = 0;
  wire logic [3:0] irqs = {ext_irq_fall_b, ext_irq_rise_b, ext_irq_fall_a, ext_irq_rise_a};

  // ==========================================================================
  // Clock, pins and instances
  // ==========================================================================
  // The clock toggles every half period.
  initial
  begin
    forever #5 clk = ~clk;
  end
  // A strong driver wins over the pin's pullup, else the outside level shows.
  assign p1_pin_in = (p1_drive.oe & p1_drive.o) | (~p1_drive.oe & p1_ext);
  ext_bus_strobes_and_ports i_dut (.clk(clk), .rstn(rstn),
    .latch_strobe_suppress(latch_strobe_suppress), .ext_req(ext_req), .ext_cmd(ext_cmd),
    .ext_busy(ext_busy), .ext_done(ext_done), .ext_rdata(ext_rdata), .p0_wr(p0_wr),
    .p0_wdata(p0_wdata), .p1_wr(p1_wr), .p1_wdata(p1_wdata), .p1_latch(p1_latch),
    .timer2_io_drive(timer2_io_drive), .serial1_transmit(serial1_transmit),
    .timer2_io_pin(timer2_io_pin), .timer2_trigger_pin(timer2_trigger_pin),
    .serial1_receive(serial1_receive), .ext_irq_rise_a(ext_irq_rise_a),
    .ext_irq_fall_a(ext_irq_fall_a), .ext_irq_rise_b(ext_irq_rise_b),
    .ext_irq_fall_b(ext_irq_fall_b), .latch_strobe(latch_strobe),
    .program_store_strobe_n(program_store_strobe_n), .low_bus_in(low_bus_in),
    .low_addr_data_bus(low_addr_data_bus), .high_addr_port(high_addr_port),
    .high_addr_drive(high_addr_drive), .p1_pin_in(p1_pin_in), .p1_drive(p1_drive));
  ext_mem_model i_mem (.clk(clk), .latch_strobe(latch_strobe),
    .program_store_strobe_n(program_store_strobe_n), .low_addr_data_bus(low_addr_data_bus),
    .high_addr_port(high_addr_port), .high_addr_drive(high_addr_drive),
    .low_bus_in(low_bus_in));

  // ==========================================================================
  // Helpers
  // ==========================================================================
  // Next value of the stimulus shift register.
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // Code-space contents that the memory model holds.
  function automatic logic [7:0] rom_byte(input logic [15:0] a);
    return a[7:0] ^ a[15:8] ^ 8'h5a;
  endfunction
  // Waits n edges and steps past their updates.
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // Compares one value and reports a mismatch.
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_tests++;
    if (got !== exp)
    begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Waits, bounded, while the latch strobe holds the given level.
  task automatic wait_while(input logic lvl);
    for (int k = 0; k < 20 && latch_strobe === lvl; k++)
      cyc(1);
  endtask
  // Runs one external access and watches the pins throughout.
  task automatic access(input logic code, input logic wr, input logic [15:0] a,
                        input logic [7:0] d, input logic [7:0] exp);
    int lo_n, ps_n;
    lo_n = 0;
    ps_n = 0;
    @(posedge clk);
    ext_cmd <= '{is_code: code, write: wr, addr: a, wdata: d};
    ext_req <= 1'b1;
    for (int k = 0; k < 40 && ext_done !== 1'b1; k++)
    begin
      cyc(1);
      if (ext_busy === 1'b1 && latch_strobe === 1'b1 && lo_n == 0)
        chk("addr_lo", {a[7:0], 8'hff}, low_addr_data_bus);
      if (ext_busy === 1'b1 && high_addr_drive === 1'b1)
        chk("addr_hi", a[15:8], high_addr_port);
      if (ext_busy === 1'b1 && latch_strobe === 1'b0)
        lo_n++;
      if (ext_busy === 1'b1 && program_store_strobe_n === 1'b0)
        ps_n++;
    end
    chk("done", 1, ext_done);
    chk("strobe_low", 5, lo_n);
    chk("store_strobe", code ? 3 : 0, ps_n);
    if (!wr)
      chk("rdata", exp, ext_rdata);
    @(posedge clk);
    ext_req <= 1'b0;
  endtask
  // Counts interrupt pulses over a window as {total, which}.
  task automatic pulses(output logic [7:0] r);
    r = 8'h00;
    for (int k = 0; k < 8; k++)
    begin
      cyc(1);
      r = r | {4'h0, irqs};
      r[7:4] = r[7:4] + 4'(irqs[0] + irqs[1] + irqs[2] + irqs[3]);
    end
  endtask
  // Prints the counts and the verdict, then stops.
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // Cuts a hang short.
  initial
  begin
    #100000;
    num_errors++;
    end_of_test();
  end

  // ==========================================================================
  // Main sequence
  // ==========================================================================
  // Reset, strobe timing, accesses, second port, interrupts, low port.
  initial
  begin
    logic [15:0] a;
    logic [7:0] w, r;
    cyc(5);
    chk("reset_pins", {8'h03, 8'h00}, {6'h00, latch_strobe, program_store_strobe_n,
      low_addr_data_bus.oe});
    chk("reset_p1", {8'hff, 8'h00}, {p1_latch, p1_drive.oe});
    @(posedge clk);
    rstn <= 1'b1;
    wait_while(1'b1);
    wait_while(1'b0);
    for (int i = 0; i < 16; i++)
    begin
      chk("strobe_shape", (i % ALE_PERIOD_CYC) < ALE_HIGH_CYC, latch_strobe);
      cyc(1);
    end
    $display("test strobe timing done");
    @(posedge clk);
    latch_strobe_suppress <= 1'b1;
    cyc(3);
    for (int i = 0; i < 16; i++)
    begin
      chk("strobe_held", 1, latch_strobe);
      cyc(1);
    end
    for (int i = 0; i < 3; i++)
    begin
      seed = lfsr(seed);
      a = (i == 0) ? 16'hffff : seed[15:0];
      access(1'b1, 1'b0, a, 8'h00, rom_byte(a));
      access(1'b0, 1'b1, ~a, seed[23:16], 8'h00);
      access(1'b0, 1'b0, ~a, 8'h00, seed[23:16]);
      latch_strobe_suppress <= (i != 0);
    end
    $display("test accesses done");
    seed = lfsr(seed);
    w = seed[7:0] & 8'hfe;
    @(posedge clk);
    p1_wdata <= w;
    p1_wr <= 1'b1;
    @(posedge clk);
    p1_wr <= 1'b0;
    cyc(4);
    chk("p1_latch", w, p1_latch);
    chk("p1_low", {~w, 8'h00}, {p1_drive.oe, p1_drive.o & ~w});
    @(posedge clk);
    p1_wdata <= 8'hff;
    p1_wr <= 1'b1;
    @(posedge clk);
    p1_wr <= 1'b0;
    r = 8'h00;
    for (int k = 0; k < 8; k++)
    begin
      cyc(1);
      r = r + 8'(p1_drive.oe[0] === 1'b1 && p1_drive.o[0] === 1'b1);
    end
    chk("kick_cycles", BOOST_CYC, r);
    chk("kick_ends", 0, p1_drive.oe);
    $display("test second port done");
    seed = lfsr(seed);
    @(posedge clk);
    p1_ext <= {5'h1f, seed[2:0]};
    cyc(4);
    chk("alt_in", seed[2:0], {serial1_receive, timer2_trigger_pin, timer2_io_pin});
    @(posedge clk);
    serial1_transmit <= 1'b0;
    cyc(4);
    chk("tx_pin", 2'b10, {p1_drive.oe[3], p1_drive.o[3]});
    @(posedge clk);
    serial1_transmit <= 1'b1;
    for (int j = 0; j < 4; j++)
    begin
      @(posedge clk);
      p1_ext[4 + j] <= 1'b0;
      pulses(r);
      chk("irq_fall", j[0] ? {4'h1, 4'(1 << j)} : 8'h00, r);
      @(posedge clk);
      p1_ext[4 + j] <= 1'b1;
      pulses(r);
      chk("irq_rise", j[0] ? 8'h00 : {4'h1, 4'(1 << j)}, r);
    end
    $display("test interrupts done");
    seed = lfsr(seed);
    @(posedge clk);
    p0_wdata <= seed[7:0];
    p0_wr <= 1'b1;
    @(posedge clk);
    p0_wr <= 1'b0;
    cyc(4);
    chk("p0_open_drain", {8'h00, ~seed[7:0]}, low_addr_data_bus);
    $display("test low port done");
    end_of_test();
  end
endmodule
